// ==== core/pan_en_a.sv ====
// Duplex negotiation, link bring-up and loopback control of a 10BASE-T physical layer.
// Assumes host control bits and jabber/transmit signals come from clk_sys logic; cable inputs are asynchronous.
// How it works
// - Capabilities travel as 16-bit code words on bursts of fast link pulses.
// - Only 10BASE-T is advertised; full duplex chosen whenever the partner offers it along with half duplex.
// - A failed attempt pulses failed, records its cause and falls back to half duplex.
// - A successful attempt pulses complete and never pulses failed for that attempt.
// - A partner sending only normal link pulses still gets a half duplex link.
// - With pause advertise set, the code word carries the pause ability bit.
// - Negotiation restarts only when an enable drops and all return high.
// - Attempts last 250 ms, followed by a 1.5 s break, repeating.
// - During the break, incoming words are ignored and nothing is sent.
// - Full duplex sends and receives together; half duplex only one at a time.
// - Loopback returns transmit data to the receiver and isolates the cable.
// - A jabber condition clears loopback automatically.
// - With negotiation on, the duplex bit is read-only and shows the negotiated mode.
`timescale 1ns/1ps
`include "pan_regs.svh"
module pan_en_a import pan_pkg::*; #(
  parameter int unsigned ATTEMPT_CYC = `PAN_ATTEMPT_CYC,
  parameter int unsigned BREAK_CYC   = `PAN_BREAK_CYC
) (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       layerEnable,
  input  wire logic       transmitterEnable,
  input  wire logic       receiverEnable,
  input  wire logic       enA,
  input  wire logic       fullDuplexSelect,
  input  wire logic       loopbackEn,
  input  wire logic       pauseAdvertiseEn,
  input  wire logic       jabberDetect,
  input  wire logic       txActive,
  input  wire logic       txData,
  input  wire logic       flpClkIn,
  input  wire logic       flpDataIn,
  input  wire logic       nlpIn,
  input  wire logic       rxLineIn,
  output logic            flpClkOut_ff,
  output logic            flpDataOut_ff,
  output logic            txLineOut_ff,
  output logic            rxDataOut_ff,
  output logic            rxDataValid_ff,
  output logic            negCompletePulse_ff,
  output logic            negFailedPulse_ff,
  output logic [1:0]      failCause_ff,
  output logic            partnerFault_ff,
  output logic            linkUp_ff,
  output logic            fullDuplex_ff,
  output logic            loopbackActive_ff
);
  localparam int NPIN = 4;

  pan_state_t  state_ff;
  pan_state_t  nxt_state;
  logic [NPIN-1:0] pinMeta_ff;
  logic [NPIN-1:0] pinSync_ff;
  logic [NPIN-1:0] pinRaw;
  logic [31:0] timer_ff;
  logic        allOn;
  logic        allOnPrev_ff;
  logic        restart;
  logic        loopReqPrev_ff;
  logic        nlpPrev_ff;
  logic        nlpSeen;
  logic [15:0] advWord;
  logic [15:0] rxWord;
  logic        rxValid;
  logic        codecTxRun;
  logic        codecRxClear;
  logic        timerDone;
  logic        wordOk;

  assign pinRaw = {rxLineIn, nlpIn, flpDataIn, flpClkIn};

  // Each cable input gets two flip-flops before any logic looks at it.
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          pinMeta_ff[gi] <= 1'b0;
          pinSync_ff[gi] <= 1'b0;
        end else begin
          pinMeta_ff[gi] <= pinRaw[gi];
          pinSync_ff[gi] <= pinMeta_ff[gi];
        end
      end
    end
  endgenerate

  assign allOn   = layerEnable && transmitterEnable && receiverEnable;
  assign restart = allOn && !allOnPrev_ff;
  assign nlpSeen = pinSync_ff[2] && !nlpPrev_ff;

  // Speed field is fixed to 10BASE-T; both duplex abilities are always offered.
  always_comb begin
    advWord = 16'h0000;
    advWord[`PAN_LCW_SEL_LSB +: 5]  = `PAN_LCW_SELECTOR;
    advWord[`PAN_LCW_10HD_BIT]      = 1'b1;
    advWord[`PAN_LCW_10FD_BIT]      = 1'b1;
    advWord[`PAN_LCW_PAUSE_BIT]     = pauseAdvertiseEn;
    advWord[`PAN_LCW_ACK_BIT]       = rxValid;
  end

  assign wordOk       = (rxWord[`PAN_LCW_SEL_LSB +: 5] == `PAN_LCW_SELECTOR) && rxWord[`PAN_LCW_10HD_BIT];
  assign codecTxRun   = (state_ff == PAN_ATTEMPT) && transmitterEnable && !loopbackActive_ff;
  assign codecRxClear = (state_ff != PAN_ATTEMPT);
  assign timerDone    = (state_ff == PAN_ATTEMPT) ? (timer_ff >= ATTEMPT_CYC - 1) : (timer_ff >= BREAK_CYC - 1);

  pan_lcw_codec u_codec (
    .clk_sys         (clk_sys),
    .rst_n           (rst_n),
    .txRun           (codecTxRun),
    .txWord          (advWord),
    .pulseClkOut_ff  (flpClkOut_ff),
    .pulseDataOut_ff (flpDataOut_ff),
    .rxClear         (codecRxClear),
    .pulseClkIn      (pinSync_ff[0]),
    .pulseDataIn     (pinSync_ff[1]),
    .rxWord_ff       (rxWord),
    .rxValid_ff      (rxValid)
  );

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      allOnPrev_ff   <= 1'b0;
      nlpPrev_ff     <= 1'b0;
      loopReqPrev_ff <= 1'b0;
    end else begin
      allOnPrev_ff   <= allOn;
      nlpPrev_ff     <= pinSync_ff[2];
      loopReqPrev_ff <= loopbackEn;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      PAN_IDLE:    if (restart) nxt_state = enA ? PAN_ATTEMPT : PAN_FORCED;
      PAN_ATTEMPT: begin
        if (rxValid && wordOk) nxt_state = PAN_LINKED;
        else if (nlpSeen) nxt_state = PAN_LINKED;
        else if (timerDone) nxt_state = PAN_BREAK;
      end
      PAN_BREAK:   if (timerDone) nxt_state = PAN_ATTEMPT;
      PAN_LINKED:  nxt_state = PAN_LINKED;
      PAN_FORCED:  nxt_state = PAN_FORCED;
      default:     nxt_state = PAN_IDLE;
    endcase
    if (!allOn) nxt_state = PAN_IDLE;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_ff <= PAN_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // One counter serves both intervals; it restarts on every state change, including re-enable.
  always_ff @(posedge clk_sys) begin
    if (!rst_n || nxt_state != state_ff) begin
      timer_ff <= 32'h0000_0000;
    end else if (state_ff == PAN_ATTEMPT || state_ff == PAN_BREAK) begin
      timer_ff <= timer_ff + 32'h0000_0001;
    end
  end

  // Events and status; a legacy partner links without either event but records why.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      negCompletePulse_ff <= 1'b0;
      negFailedPulse_ff   <= 1'b0;
      failCause_ff        <= `PAN_CAUSE_NONE;
      partnerFault_ff     <= 1'b0;
      linkUp_ff           <= 1'b0;
    end else begin
      negCompletePulse_ff <= 1'b0;
      negFailedPulse_ff   <= 1'b0;
      linkUp_ff           <= (nxt_state == PAN_LINKED) || (nxt_state == PAN_FORCED);
      if (restart) begin
        failCause_ff    <= `PAN_CAUSE_NONE;
        partnerFault_ff <= 1'b0;
      end else if (state_ff == PAN_ATTEMPT) begin
        if (rxValid && wordOk) begin
          negCompletePulse_ff <= 1'b1;
          failCause_ff        <= `PAN_CAUSE_NONE;
          partnerFault_ff     <= rxWord[`PAN_LCW_RFAULT_BIT];
        end else if (nlpSeen) begin
          failCause_ff <= `PAN_CAUSE_LEGACY;
        end else if (timerDone) begin
          negFailedPulse_ff <= 1'b1;
          failCause_ff      <= (rxValid || failCause_ff == `PAN_CAUSE_BAD_WORD) ?
                               `PAN_CAUSE_BAD_WORD : `PAN_CAUSE_NO_FLP;
        end else if (rxValid) begin
          failCause_ff <= `PAN_CAUSE_BAD_WORD;
        end
      end
    end
  end

  // Duplex follows the host bit only when negotiation is off; otherwise the result alone sets it.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      fullDuplex_ff <= 1'b0;
    end else if (!enA) begin
      fullDuplex_ff <= fullDuplexSelect;
    end else if (state_ff == PAN_ATTEMPT && rxValid && wordOk) begin
      fullDuplex_ff <= rxWord[`PAN_LCW_10FD_BIT];
    end else if (state_ff == PAN_ATTEMPT && (nlpSeen || timerDone)) begin
      fullDuplex_ff <= 1'b0;
    end else if (state_ff == PAN_IDLE) begin
      fullDuplex_ff <= 1'b0;
    end
  end

  // Jabber wins over a simultaneous loopback request so the fault can never be masked.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      loopbackActive_ff <= 1'b0;
    end else if (jabberDetect) begin
      loopbackActive_ff <= 1'b0;
    end else if (!loopbackEn) begin
      loopbackActive_ff <= 1'b0;
    end else if (!loopReqPrev_ff) begin
      loopbackActive_ff <= 1'b1;
    end
  end

  // Half duplex blanks reception while transmitting; loopback cuts the cable both ways.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      txLineOut_ff   <= 1'b0;
      rxDataOut_ff   <= 1'b0;
      rxDataValid_ff <= 1'b0;
    end else if (loopbackActive_ff) begin
      txLineOut_ff   <= 1'b0;
      rxDataOut_ff   <= txData;
      rxDataValid_ff <= txActive;
    end else begin
      txLineOut_ff   <= txData && txActive && transmitterEnable && linkUp_ff;
      rxDataOut_ff   <= pinSync_ff[3];
      rxDataValid_ff <= receiverEnable && linkUp_ff && (fullDuplex_ff || !txActive);
    end
  end
endmodule

// ==== include/pan_regs.svh ====
// Constants of the duplex negotiation block: timing, code word layout and status codes.
// Assumes a 125 MHz system clock; the checker and bench write the cause codes as literals, not by name.
`ifndef PAN_REGS_SVH
`define PAN_REGS_SVH

`define PAN_CLK_KHZ         125000
`define PAN_ATTEMPT_MS      250
`define PAN_BREAK_MS        1500
`define PAN_ATTEMPT_CYC     (`PAN_ATTEMPT_MS * `PAN_CLK_KHZ)
`define PAN_BREAK_CYC       (`PAN_BREAK_MS * `PAN_CLK_KHZ)
`define PAN_FLP_BIT_NS      64000
`define PAN_CLK_NS          8
`define PAN_FLP_BIT_CYC     (`PAN_FLP_BIT_NS / `PAN_CLK_NS)
`define PAN_LCW_BITS        16
`define PAN_LCW_SELECTOR    5'h01
`define PAN_LCW_SEL_LSB     0
`define PAN_LCW_10HD_BIT    5
`define PAN_LCW_10FD_BIT    6
`define PAN_LCW_PAUSE_BIT   10
`define PAN_LCW_RFAULT_BIT  13
`define PAN_LCW_ACK_BIT     14
`define PAN_CAUSE_NONE      2'h0
`define PAN_CAUSE_NO_FLP    2'h1
`define PAN_CAUSE_LEGACY    2'h2
`define PAN_CAUSE_BAD_WORD  2'h3

`endif

// ==== include/pan_pkg.sv ====
// Types shared by the duplex negotiation block.
// Assumes the constants header is compiled alongside.
package pan_pkg;
  typedef enum logic [2:0] {
    PAN_IDLE,
    PAN_ATTEMPT,
    PAN_BREAK,
    PAN_LINKED,
    PAN_FORCED
  } pan_state_t;
endpackage

// ==== core/pan_lcw_codec.sv ====
// Serialises and collects 16-bit link code words on a clock-and-data pulse pair.
// Assumes the receive inputs are already synchronised to clk_sys.
`timescale 1ns/1ps
`include "pan_regs.svh"
module pan_lcw_codec import pan_pkg::*; (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        txRun,
  input  wire logic [15:0] txWord,
  output logic             pulseClkOut_ff,
  output logic             pulseDataOut_ff,
  input  wire logic        rxClear,
  input  wire logic        pulseClkIn,
  input  wire logic        pulseDataIn,
  output logic [15:0]      rxWord_ff,
  output logic             rxValid_ff
);
  localparam logic [15:0] BIT_CYC = 16'(`PAN_FLP_BIT_CYC);

  logic [15:0] bitTimer_ff;
  logic [3:0]  txIdx_ff;
  logic [3:0]  rxCnt_ff;
  logic [15:0] rxShift_ff;
  logic        clkPrev_ff;

  // The word repeats for as long as txRun stays high; bits go out most significant first.
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !txRun) begin
      bitTimer_ff     <= 16'h0000;
      txIdx_ff        <= 4'hF;
      pulseClkOut_ff  <= 1'b0;
      pulseDataOut_ff <= 1'b0;
    end else if (bitTimer_ff == BIT_CYC - 16'h0001) begin
      bitTimer_ff     <= 16'h0000;
      txIdx_ff        <= txIdx_ff - 4'h1;
      pulseClkOut_ff  <= 1'b1;
      pulseDataOut_ff <= txWord[txIdx_ff];
    end else begin
      bitTimer_ff     <= bitTimer_ff + 16'h0001;
      pulseClkOut_ff  <= 1'b0;
    end
  end

  // A partial word left over from before a clear is dropped rather than merged.
  always_ff @(posedge clk_sys) begin
    if (!rst_n || rxClear) begin
      clkPrev_ff <= 1'b0;
      rxCnt_ff   <= 4'h0;
      rxShift_ff <= 16'h0000;
      rxWord_ff  <= 16'h0000;
      rxValid_ff <= 1'b0;
    end else begin
      clkPrev_ff <= pulseClkIn;
      rxValid_ff <= 1'b0;
      if (pulseClkIn && !clkPrev_ff) begin
        rxShift_ff <= {rxShift_ff[14:0], pulseDataIn};
        rxCnt_ff   <= rxCnt_ff + 4'h1;
        if (rxCnt_ff == 4'hF) begin
          rxWord_ff  <= {rxShift_ff[14:0], pulseDataIn};
          rxValid_ff <= 1'b1;
        end
      end
    end
  end
endmodule

// ==== sim/pan_en_a_sva.sv ====
// Checker of the duplex negotiation block.
// Assumes it is bound to pan_en_a and sees its ports only.
`timescale 1ns/1ps
module pan_en_a_sva #(
  parameter int unsigned ATTEMPT_CYC = 2000,
  parameter int unsigned BREAK_CYC   = 3000
) (
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic       layerEnable,
  input wire logic       transmitterEnable,
  input wire logic       receiverEnable,
  input wire logic       txActive,
  input wire logic       txData,
  input wire logic       jabberDetect,
  input wire logic       flpClkOut_ff,
  input wire logic       txLineOut_ff,
  input wire logic       rxDataOut_ff,
  input wire logic       rxDataValid_ff,
  input wire logic       negCompletePulse_ff,
  input wire logic       negFailedPulse_ff,
  input wire logic       linkUp_ff,
  input wire logic       fullDuplex_ff,
  input wire logic       loopbackActive_ff,
  input wire logic [1:0] failCause_ff
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic [31:0] brkCnt_ff;
  // Two cycles are taken off the break so the edges of the window never fire falsely.
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !(layerEnable && transmitterEnable && receiverEnable))
      brkCnt_ff <= '0;
    else if (negFailedPulse_ff)
      brkCnt_ff <= BREAK_CYC - 2;
    else if (brkCnt_ff != 0)
      brkCnt_ff <= brkCnt_ff - 1;
  end
  a_complete_only: assert property (negCompletePulse_ff |-> linkUp_ff && !negFailedPulse_ff
    ##1 !negCompletePulse_ff) else $error("complete pulse malformed");
  a_failed_half: assert property (negFailedPulse_ff |-> !fullDuplex_ff
    && failCause_ff inside {2'h1, 2'h3} ##1 !negFailedPulse_ff) else $error("failure not half");
  a_break_silent: assert property (brkCnt_ff != 0 |-> !negCompletePulse_ff && !flpClkOut_ff)
    else $error("activity in break");
  a_legacy_half: assert property ($rose(linkUp_ff) && failCause_ff == 2'h2
    |-> !fullDuplex_ff && !negCompletePulse_ff) else $error("legacy link not half");
  a_loop_isolate: assert property (loopbackActive_ff && $past(loopbackActive_ff) |-> !txLineOut_ff
    && rxDataOut_ff == $past(txData) && rxDataValid_ff == $past(txActive)) else $error("loopback path");
  a_jabber_clear: assert property (jabberDetect |=> !loopbackActive_ff)
    else $error("jabber kept loopback");
  a_half_no_rx: assert property ($past(linkUp_ff && !fullDuplex_ff && txActive && !loopbackActive_ff)
    |-> !rxDataValid_ff) else $error("half duplex received while sending");
  a_drop_link: assert property ($fell(layerEnable && transmitterEnable && receiverEnable)
    |-> ##2 !linkUp_ff) else $error("link kept after disable");
endmodule

// ==== sim/pan_link_partner.sv ====
// Cable partner: sends code words on fast pulses, or a legacy link pulse.
// Assumes the bench calls its tasks; data idles at the inverse of its last bit.
`timescale 1ns/1ps
module pan_link_partner (
  input  wire logic clk_sys,
  output logic      flpClk,
  output logic      flpData,
  output logic      nlp
);
  initial begin
    flpClk = 1'b0;
    flpData = 1'b0;
    nlp = 1'b0;
  end
  // Data settles a cycle before the clock rises, so the receiver never sees a race.
  task automatic sendWord(input logic [15:0] w);
    for (int i = 15; i >= 0; i--) begin
      @(negedge clk_sys);
      flpData = w[i];
      @(negedge clk_sys);
      flpClk = 1'b1;
      repeat (2) @(negedge clk_sys);
      flpClk = 1'b0;
    end
    @(negedge clk_sys);
    flpData = ~w[0];
  endtask
  task automatic sendNlp();
    @(negedge clk_sys);
    nlp = 1'b1;
    repeat (2) @(negedge clk_sys);
    nlp = 1'b0;
  endtask
endmodule

// ==== sim/tb.sv ====
// Self-checking bench of the duplex negotiation block.
// Assumes short attempt and break counts; the partner model drives the cable.
`timescale 1ns/1ps
module tb;
  localparam int ATT = 52000;
  localparam int BRK = 3000;
  logic clk_sys = 1'b0, rst_n = 1'b0, layerEnable = 1'b0, transmitterEnable = 1'b0;
  logic receiverEnable = 1'b0, enA = 1'b0, fullDuplexSelect = 1'b0, loopbackEn = 1'b0;
  logic pauseAdvertiseEn = 1'b0, jabberDetect = 1'b0, txActive = 1'b0, txData = 1'b0;
  logic flpClkIn, flpDataIn, nlpIn, flpClkOut_ff, flpDataOut_ff, txLineOut_ff, rxDataOut_ff;
  logic rxDataValid_ff, negCompletePulse_ff, negFailedPulse_ff, partnerFault_ff, linkUp_ff;
  logic fullDuplex_ff, loopbackActive_ff, sawC, sawF;
  logic [1:0] failCause_ff;
  logic [7:0] cap;
  logic rxLine = 1'b0;
  int miscompares = 0, checks_done = 0, b = 0;
  always #4 clk_sys = ~clk_sys;
  pan_en_a #(.ATTEMPT_CYC(ATT), .BREAK_CYC(BRK)) i_pan_en_a (
    .clk_sys(clk_sys), .rst_n(rst_n), .layerEnable(layerEnable), .enA(enA),
    .transmitterEnable(transmitterEnable), .receiverEnable(receiverEnable),
    .fullDuplexSelect(fullDuplexSelect), .loopbackEn(loopbackEn), .pauseAdvertiseEn(pauseAdvertiseEn),
    .jabberDetect(jabberDetect), .txActive(txActive), .txData(txData), .flpClkIn(flpClkIn),
    .flpDataIn(flpDataIn), .nlpIn(nlpIn), .rxLineIn(rxLine), .flpClkOut_ff(flpClkOut_ff),
    .flpDataOut_ff(flpDataOut_ff), .txLineOut_ff(txLineOut_ff), .rxDataOut_ff(rxDataOut_ff),
    .rxDataValid_ff(rxDataValid_ff), .negCompletePulse_ff(negCompletePulse_ff),
    .negFailedPulse_ff(negFailedPulse_ff), .failCause_ff(failCause_ff), .partnerFault_ff(partnerFault_ff),
    .linkUp_ff(linkUp_ff), .fullDuplex_ff(fullDuplex_ff), .loopbackActive_ff(loopbackActive_ff));
  pan_link_partner i_pan_link_partner (.clk_sys(clk_sys), .flpClk(flpClkIn), .flpData(flpDataIn), .nlp(nlpIn));
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic runFor(input int lim, input bit untilFail);
    sawC = 1'b0;
    sawF = 1'b0;
    for (int n = 0; n < lim; n++) begin
      @(negedge clk_sys);
      if (negCompletePulse_ff === 1'b1) sawC = 1'b1;
      if (negFailedPulse_ff === 1'b1) sawF = 1'b1;
      if (untilFail && sawF) return;
    end
    if (untilFail) begin
      miscompares++;
      print_verdict();
    end
  endtask
  // Layer first, then transmitter and receiver, the way the host brings it up.
  task automatic linkOn(input logic an);
    @(negedge clk_sys);
    enA = an;
    layerEnable = 1'b1;
    repeat (4) @(negedge clk_sys);
    transmitterEnable = 1'b1;
    receiverEnable = 1'b1;
  endtask
  task automatic linkOff(input string t);
    @(negedge clk_sys);
    layerEnable = 1'b0;
    transmitterEnable = 1'b0;
    receiverEnable = 1'b0;
    repeat (3) @(negedge clk_sys);
    $display("test %s done", t);
  endtask
  initial begin
    repeat (5) @(negedge clk_sys);
    rst_n = 1'b1;
    @(negedge clk_sys);
    chk("linkUp", linkUp_ff, 8'h00);
    chk("cause", failCause_ff, 8'h00);
    txActive = 1'b1;
    txData = 1'b1;
    rxLine = 1'b1;
    fullDuplexSelect = 1'b1;
    linkOn(1'b0);
    runFor(3, 1'b0);
    chk("forced fd", fullDuplex_ff, 8'h01);
    chk("rx line", rxDataOut_ff, 8'h01);
    chk("rx valid", rxDataValid_ff, 8'h01);
    chk("tx line", txLineOut_ff, 8'h01);
    linkOff("forced");
    for (int k = 0; k < 2; k++) begin
      fullDuplexSelect = k[0];
      linkOn(1'b1);
      i_pan_link_partner.sendWord(k ? 16'h2021 : 16'h0061);
      runFor(20, 1'b0);
      chk("complete", sawC, 8'h01);
      chk("failed", sawF, 8'h00);
      chk("fault", partnerFault_ff, k == 1);
      chk("fd", fullDuplex_ff, k == 0);
      chk("rx valid", rxDataValid_ff, k == 0);
      linkOff("negotiate");
    end
    linkOn(1'b1);
    i_pan_link_partner.sendWord(16'h0040);
    runFor(8, 1'b0);
    chk("bad word", failCause_ff, 8'h03);
    i_pan_link_partner.sendNlp();
    runFor(10, 1'b0);
    chk("legacy link", linkUp_ff, 8'h01);
    chk("legacy fd", fullDuplex_ff, 8'h00);
    chk("legacy cause", failCause_ff, 8'h02);
    linkOff("legacy");
    txActive = 1'b0;
    pauseAdvertiseEn = 1'b1;
    cap = '0;
    // Synchronising pass: options set with negotiation off, then a scaled wait before negotiating.
    linkOn(1'b0);
    runFor(ATT / 100, 1'b0);
    chk("sync link", linkUp_ff, 8'h01);
    linkOff("sync");
    linkOn(1'b1);
    for (int n = 0; n < ATT && b < 6; n++) begin
      @(negedge clk_sys);
      if (flpClkOut_ff === 1'b1) begin
        cap = {cap[6:0], flpDataOut_ff};
        b++;
      end
    end
    chk("word top", cap, 8'h01);
    runFor(ATT, 1'b1);
    chk("fail cause", failCause_ff, 8'h01);
    chk("fail fd", fullDuplex_ff, 8'h00);
    i_pan_link_partner.sendWord(16'h0061);
    runFor(20, 1'b0);
    chk("break ignore", sawC, 8'h00);
    runFor(BRK, 1'b0);
    i_pan_link_partner.sendWord(16'h0061);
    runFor(20, 1'b0);
    chk("retry", sawC, 8'h01);
    linkOff("timeout");
    linkOn(1'b0);
    loopbackEn = 1'b1;
    txActive = 1'b1;
    txData = 1'b1;
    runFor(3, 1'b0);
    chk("loop on", loopbackActive_ff, 8'h01);
    chk("loop tx", txLineOut_ff, 8'h00);
    chk("loop rx", rxDataOut_ff, 8'h01);
    txData = 1'b0;
    runFor(2, 1'b0);
    chk("loop rx", rxDataOut_ff, 8'h00);
    jabberDetect = 1'b1;
    runFor(2, 1'b0);
    chk("jabber", loopbackActive_ff, 8'h00);
    linkOff("loopback");
    print_verdict();
  end
endmodule
bind pan_en_a pan_en_a_sva #(.ATTEMPT_CYC(ATTEMPT_CYC), .BREAK_CYC(BREAK_CYC)) i_pan_en_a_sva (
  .clk_sys(clk_sys), .rst_n(rst_n), .layerEnable(layerEnable), .transmitterEnable(transmitterEnable),
  .receiverEnable(receiverEnable), .txActive(txActive), .txData(txData), .jabberDetect(jabberDetect),
  .flpClkOut_ff(flpClkOut_ff), .txLineOut_ff(txLineOut_ff), .rxDataOut_ff(rxDataOut_ff),
  .rxDataValid_ff(rxDataValid_ff), .negCompletePulse_ff(negCompletePulse_ff),
  .negFailedPulse_ff(negFailedPulse_ff), .linkUp_ff(linkUp_ff), .fullDuplex_ff(fullDuplex_ff),
  .loopbackActive_ff(loopbackActive_ff), .failCause_ff(failCause_ff));
